// [pll_band_divider_lock_control.sv]
// How it works
// - 5-bit band select per PLL, 0..27
// - 5-bit charge pump current, bits 20:16
// - four 8-bit divider fields in one register
// - codes 0..3 divide 256..259, else value
// - half-step bit forces divide by 4.5
// - status bits 21, 23 show lock
// - enable bit routes AND of losses out
// - feedback divider writes apply at once
// - divider is 8-bit integer, 28-bit fraction
// - order 0 integer, 1..4 fractional
`timescale 1ns/1ns
`include "pll_cfg.svh"

module pll_band_divider_lock_control #(
  parameter int NUM_OUTPUTS = 4,
  parameter int NUM_PLLS = 2
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register port from serial controller
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // analog side: lock detect, serial data to share pin
  input wire logic [1:0] pll_locked_in,
  input wire logic serial_data_in,
  output logic serial_out_lock_loss_pin_out,
  // per-PLL loop settings
  output logic [1:0][4:0] band_select_out,
  output logic [1:0] gain_band_out,
  output logic [1:0][4:0] charge_pump_current_out,
  output logic [1:0][2:0] modulator_order_out,
  output logic [1:0] fractional_mode_out,
  output logic [1:0][35:0] feedback_divider_out,
  output logic [1:0] fb_divider_reset_out,
  // output divider ticks
  output logic [3:0] out_tick_out
);
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // the index map below has exactly four outputs and two loops
  if (NUM_OUTPUTS != 4 || NUM_PLLS != 2)
  begin : g_bad_size
    $error("pll control: register map serves 4 outputs, 2 PLLs");
  end

  // ------------------------------------------------------------------
  // register array, addresses 0..14; 15 is status
  // ------------------------------------------------------------------
  pll_pkg::reg_word_t regs [0:14]; // written words, kept as written
  logic wr_en; // write to a storable register
  logic [1:0] loss_en; // per-PLL loss route enables
  logic route_loss; // either enable set
  logic both_lost; // AND of both loss indications
  pll_pkg::reg_word_t status_word; // live status view
  pll_pkg::reg_word_t read_word; // selected read data

  // status is never stored, so writes to it fall away
  assign wr_en = reg_write_in && (reg_addr_in != `CFG_REG_STATUS);

  // ------------------------------------------------------------------
  // register writes; host keeps factory bits intact itself
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 15; i++)
        regs[i] <= `CFG_REG_RESET;
    end
    else if (wr_en)
    begin
      // reserved bits kept too, so read-modify-write is safe
      regs[reg_addr_in] <= reg_wdata_in;
    end
  end

  // ------------------------------------------------------------------
  // read path: status bits sampled at the read itself
  // ------------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[`CFG_LOCK1_BIT] = pll_locked_in[0];
    status_word[`CFG_LOCK2_BIT] = pll_locked_in[1];
  end
  // index 15 never reaches the array, so its missing slot is harmless
  assign read_word = (reg_addr_in == `CFG_REG_STATUS) ?
    status_word : regs[reg_addr_in];

  // registered read answer, one cycle after the request
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= '0;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in)
        reg_rdata_out <= read_word;
    end
  end

  // ------------------------------------------------------------------
  // shared pin: serial data, or lock loss when routed
  // ------------------------------------------------------------------
  // bit 0 of each fraction word doubles as the route enable
  assign loss_en[0] = regs[`CFG_REG_FB_FRAC1][`CFG_LOSS_EN_BIT];
  assign loss_en[1] = regs[`CFG_REG_FB_FRAC2][`CFG_LOSS_EN_BIT];
  assign route_loss = |loss_en;
  // loss is the inverse of lock; pin high only when both lost
  assign both_lost = ~pll_locked_in[0] & ~pll_locked_in[1];

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      serial_out_lock_loss_pin_out <= 1'b0;
    else
      serial_out_lock_loss_pin_out <= route_loss ?
        both_lost : serial_data_in;
  end

  // ------------------------------------------------------------------
  // per-PLL settings
  // ------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_pll
    // indices of this loop's control, fraction and gain words
    localparam logic [3:0] CTRL_IDX = p ? `CFG_REG_CTRL2 : `CFG_REG_CTRL1;
    localparam logic [3:0] FRAC_IDX = p ? `CFG_REG_FB_FRAC2 :
      `CFG_REG_FB_FRAC1;
    localparam logic [3:0] GAIN_IDX = p ? `CFG_REG_GAIN2 : `CFG_REG_GAIN1;
    logic ctrl_wr; // write to this PLL's control word
    logic frac_wr; // write to this PLL's fraction word
    logic toggled; // reset bit changed by this write
    pll_pkg::reg_word_t ctrl_word; // control word after this cycle
    pll_pkg::fb_value_t next_fb; // divider value after this cycle
    pll_pkg::fb_mode_t next_mode; // mode after this cycle

    assign ctrl_wr = reg_write_in && (reg_addr_in == CTRL_IDX);
    assign frac_wr = reg_write_in && (reg_addr_in == FRAC_IDX);
    assign ctrl_word = ctrl_wr ? reg_wdata_in : regs[CTRL_IDX];
    // host toggles the bit after an order change
    assign toggled = ctrl_wr && (reg_wdata_in[`CFG_FB_RESET_BIT] !=
      regs[CTRL_IDX][`CFG_FB_RESET_BIT]);
    // written value forwarded so it applies on the write edge
    assign next_fb.int_part = ctrl_word[`CFG_INT_LSB +: 8];
    assign next_fb.frac_part = frac_wr ?
      reg_wdata_in[`CFG_FRAC_LSB +: 28] :
      regs[FRAC_IDX][`CFG_FRAC_LSB +: 28];
    assign next_mode = (ctrl_word[`CFG_ORDER_LSB +: 3] == 3'h0) ?
      pll_pkg::mode_integer : pll_pkg::mode_fractional;

    // outputs held in flops; the loop slews, the word does not
    always_ff @(posedge clock_in)
    begin
      if (reset_in)
      begin
        band_select_out[p] <= '0;
        gain_band_out[p] <= 1'b0;
        charge_pump_current_out[p] <= '0;
        modulator_order_out[p] <= '0;
        fractional_mode_out[p] <= 1'b0;
        feedback_divider_out[p] <= '0;
        fb_divider_reset_out[p] <= 1'b0;
      end
      else
      begin
        band_select_out[p] <= ctrl_word[`CFG_BAND_LSB +: 5];
        // limitation: gain bit is not forwarded, so it lags one cycle
        gain_band_out[p] <= regs[GAIN_IDX][`CFG_GAIN_BIT];
        charge_pump_current_out[p] <= ctrl_word[`CFG_CP_LSB +: 5];
        modulator_order_out[p] <= ctrl_word[`CFG_ORDER_LSB +: 3];
        fractional_mode_out[p] <= (next_mode == pll_pkg::mode_fractional);
        feedback_divider_out[p] <= next_fb;
        fb_divider_reset_out[p] <= toggled;
      end
    end
  end

  // ------------------------------------------------------------------
  // output dividers, one channel per output
  // ------------------------------------------------------------------
  for (genvar o = 0; o < 4; o++)
  begin : g_out
    // ratio read live; the divider defers it to its next reload
    out_div_if chan ();
    // each output owns one byte of the packed word
    assign chan.ratio = regs[`CFG_REG_OUT_DIV][8*o +: 8];
    // half bits sit one per output above the low byte
    assign chan.half_mode =
      regs[`CFG_REG_HALF_MODE][`CFG_HALF_LSB + o];

    out_divider #(
      .CNT_W(9)
    ) u_div (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .chan(chan.div)
    );

    // tick leaves through a flop of its own
    always_ff @(posedge clock_in)
    begin
      if (reset_in)
        out_tick_out[o] <= 1'b0;
      else
        out_tick_out[o] <= chan.tick;
    end
  end
endmodule : pll_band_divider_lock_control

// [pll_cfg.svh]
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH

// ------------------------------------------------------------------
// register indices (register port address)
// ------------------------------------------------------------------
`define CFG_REG_HALF_MODE 4'h3
`define CFG_REG_OUT_DIV 4'h5
`define CFG_REG_FB_FRAC1 4'h6
`define CFG_REG_CTRL1 4'h7
`define CFG_REG_FB_FRAC2 4'h8
`define CFG_REG_CTRL2 4'h9
`define CFG_REG_GAIN1 4'hc
`define CFG_REG_GAIN2 4'he
`define CFG_REG_STATUS 4'hf

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CFG_BAND_LSB 0
`define CFG_FB_RESET_BIT 14
`define CFG_CP_LSB 16
`define CFG_INT_LSB 21
`define CFG_ORDER_LSB 29
`define CFG_FRAC_LSB 4
`define CFG_LOSS_EN_BIT 0
`define CFG_GAIN_BIT 31
`define CFG_LOCK1_BIT 21
`define CFG_LOCK2_BIT 23
`define CFG_HALF_LSB 8

// ------------------------------------------------------------------
// reset values and divider counts
// ------------------------------------------------------------------
`define CFG_REG_RESET 32'h0000_0000
`define CFG_DIV_WRAP_BASE 9'h100
`define CFG_DIV_MIN_FIELD 8'h04
`define CFG_HALF_SHORT 9'h003
`define CFG_HALF_LONG 9'h004

`endif

// [pll_pkg.sv]
package pll_pkg;
  // register word and index
  typedef logic [31:0] reg_word_t;
  typedef logic [3:0] reg_index_t;
  // feedback divider operating mode
  typedef enum logic {mode_integer, mode_fractional} fb_mode_t;
  // applied feedback divider: integer and fraction parts
  typedef struct packed {
    logic [7:0] int_part;
    logic [27:0] frac_part;
  } fb_value_t;
endpackage : pll_pkg

// [out_div_if.sv]
`timescale 1ns/1ns
// one output divider channel: ratio in, tick back
interface out_div_if;
  logic [7:0] ratio; // encoded ratio field
  logic half_mode; // divide by 4.5
  logic tick; // one-cycle pulse per output period
  modport ctrl (output ratio, output half_mode, input tick);
  modport div (input ratio, input half_mode, output tick);
endinterface : out_div_if

// [out_divider.sv]
`timescale 1ns/1ns
`include "pll_cfg.svh"

module out_divider #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // channel
  out_div_if.div chan
);
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // refuse a counter that cannot hold the largest reload
  if (CNT_W < 9)
  begin : g_bad_width
    $error("out_divider: counter too narrow for ratio 259");
  end

  // ------------------------------------------------------------------
  // ratio decode
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] count; // cycles left in this period
  logic phase; // alternates 4 and 5 in half mode
  logic [8:0] full_ratio; // decoded 4..259
  logic [8:0] term; // reload value, ratio minus one
  // small codes wrap to 256..259
  assign full_ratio = (chan.ratio < `CFG_DIV_MIN_FIELD) ?
    (`CFG_DIV_WRAP_BASE | {1'b0, chan.ratio}) : {1'b0, chan.ratio};
  // half mode ignores the ratio field; 4 then 5 averages 4.5
  assign term = chan.half_mode ?
    (phase ? `CFG_HALF_LONG : `CFG_HALF_SHORT) : (full_ratio - 9'h001);

  // ------------------------------------------------------------------
  // counter: new ratio lands at next reload, avoiding runt periods
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      count <= '0;
      phase <= 1'b0;
      chan.tick <= 1'b0;
    end
    else if (count == '0)
    begin
      count <= CNT_W'(term);
      phase <= ~phase;
      chan.tick <= 1'b1;
    end
    else
    begin
      count <= count - 1'b1;
      chan.tick <= 1'b0;
    end
  end
endmodule : out_divider

// [pll_host_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// register port host model
// ----------------------------------------
module pll_host_model (
  // clock
  input wire logic clock_in,
  // register port
  output logic [3:0] addr_out,
  output logic [31:0] wdata_out,
  output logic write_out,
  output logic read_out,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in
);
  // quiet port at time zero
  initial {addr_out, wdata_out, write_out, read_out} = '0;
  // one write; strobe covers exactly one rising edge
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clock_in);
    {addr_out, wdata_out, write_out} = {a, d, 1'b1};
    @(negedge clock_in);
    write_out = 1'b0;
    // released lines must not look like live data
    {addr_out, wdata_out} = ~{a, d};
  endtask : wr
  // one read; answer is registered on the read edge and taken at the next falling edge
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge clock_in);
    {addr_out, read_out} = {a, 1'b1};
    @(negedge clock_in);
    read_out = 1'b0;
    addr_out = ~a;
    d = rvalid_in ? rdata_in : 'x;
  endtask : rd
  // control word, then a flip of the divider reset bit
  task set_order(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    wr(a, d ^ 32'h0000_4000);
  endtask : set_order
  // gain bit matches band; other bits written back as read
  task set_gain(input logic [3:0] a, input logic [4:0] band);
    logic [31:0] v;
    rd(a, v);
    wr(a, {band > 5'h0d, v[30:0]});
  endtask : set_gain
endmodule : pll_host_model

// [pll_band_divider_lock_control_sva.sv]
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module pll_band_divider_lock_control_sva (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // lock and shared pin
  input wire logic [1:0] pll_locked_in,
  input wire logic serial_data_in,
  input wire logic serial_out_lock_loss_pin_out,
  // settings
  input wire logic [1:0][4:0] band_select_out,
  input wire logic [1:0][4:0] charge_pump_current_out,
  input wire logic [1:0] fractional_mode_out,
  input wire logic [1:0][35:0] feedback_divider_out,
  input wire logic [1:0] fb_divider_reset_out,
  input wire logic [3:0] out_tick_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic en6, en8; // route enables as written on the port
  wire wr7 = reg_write_in && reg_addr_in == 4'h7;
  wire wr8 = reg_write_in && reg_addr_in == 4'h8;
  wire loss_en = en6 | en8;
  wire both_lost = ~|pll_locked_in;
  // shadow of the route bits, since the checker sees no registers
  always_ff @(posedge clock_in)
    if (reset_in) {en6, en8} <= 2'b00;
    else if (reg_write_in && reg_addr_in == 4'h6) en6 <= reg_wdata_in[0];
    else if (wr8) en8 <= reg_wdata_in[0];
  sequence s_rd15; reg_read_in && reg_addr_in == 4'hf; endsequence
  sequence s_quiet; !out_tick_out[0] [*3]; endsequence
  property p_band; wr7 |=> band_select_out[0] == $past(reg_wdata_in[4:0]);
  endproperty
  a_band: assert property (p_band) else $error("band");
  property p_cp;
    wr7 |=> charge_pump_current_out[0] == $past(reg_wdata_in[20:16]);
  endproperty
  a_cp: assert property (p_cp) else $error("pump current");
  property p_mode;
    wr7 |=> fractional_mode_out[0] == ($past(reg_wdata_in[31:29]) != 3'h0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_frac;
    wr8 |=> feedback_divider_out[1][27:0] == $past(reg_wdata_in[31:4]);
  endproperty
  a_frac: assert property (p_frac) else $error("fraction");
  property p_lock; s_rd15 |=> reg_rvalid_out
    && reg_rdata_out[21] == $past(pll_locked_in[0])
    && reg_rdata_out[23] == $past(pll_locked_in[1]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock status");
  property p_rst; fb_divider_reset_out[0] |-> $past(wr7); endproperty
  a_rst: assert property (p_rst) else $error("divider reset");
  property p_pin; !$past(reset_in) |-> serial_out_lock_loss_pin_out ==
    ($past(loss_en) ? $past(both_lost) : $past(serial_data_in));
  endproperty
  a_pin: assert property (p_pin) else $error("shared pin");
  property p_tick; out_tick_out[0] |=> s_quiet; endproperty
  a_tick: assert property (p_tick) else $error("tick");
endmodule : pll_band_divider_lock_control_sva

// [pll_band_divider_lock_control_test.sv]
`timescale 1ns/1ns
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module pll_band_divider_lock_control_test;
  logic clock_in = 0, reset_in = 1, serial_data_in = 0;
  logic [1:0] pll_locked_in = 2'b00;
  logic [3:0] reg_addr_in, out_tick_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, v;
  logic reg_write_in, reg_read_in, reg_rvalid_out;
  logic serial_out_lock_loss_pin_out;
  logic [1:0][4:0] band_select_out, charge_pump_current_out;
  logic [1:0][2:0] modulator_order_out;
  logic [1:0][35:0] feedback_divider_out;
  logic [1:0] gain_band_out, fractional_mode_out, fb_divider_reset_out;
  int errors = 0, tests_run = 0, n, m;
  always #25 clock_in = ~clock_in;
  pll_band_divider_lock_control dut (.*);
  pll_host_model host (.clock_in, .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .write_out(reg_write_in),
    .read_out(reg_read_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out));
  task check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    errors += (seen !== exp);
  endtask : check
  // cycles between two ticks of one output, bounded
  task period(input int ch, output int p);
    p = 0;
    repeat (600) if (out_tick_out[ch] !== 1'b1) @(negedge clock_in);
    @(negedge clock_in);
    repeat (600) if (out_tick_out[ch] !== 1'b1) @(negedge clock_in) p++;
    p++;
  endtask : period
  task t_reset;
    host.rd(4'h5, v);
    check(v, 0);
    period(0, n);
    check(n, 256);
    $display("reset test done");
  endtask : t_reset
  // bands at both gain edges, order codes 0..4, both loops
  task t_band;
    logic [4:0] b;
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
    begin
      b = 5'(32'h1b0e0d00 >> (8 * (i % 4)));
      d = {3'(i % 5), 8'(60 + i), 5'(15 + i), 11'h000, b};
      host.set_order(i[2] ? 4'h9 : 4'h7, d);
      check(fb_divider_reset_out[i[2]], 1);
      check(band_select_out[i[2]], b);
      check(charge_pump_current_out[i[2]], 15 + i);
      check(modulator_order_out[i[2]], i % 5);
      check(fractional_mode_out[i[2]], i % 5 != 0);
      check(feedback_divider_out[i[2]][35:28], 60 + i);
      host.set_gain(i[2] ? 4'he : 4'hc, b);
      // gain output follows the stored word one cycle later
      @(negedge clock_in);
      check(gain_band_out[i[2]], b > 13);
      host.wr(i[2] ? 4'h8 : 4'h6, 32'habcdef50 + i * 16);
      check(feedback_divider_out[i[2]][27:0], 28'habcdef5 + i);
    end
    $display("band test done");
  endtask : t_band
  task t_div;
    host.wr(4'h5, 32'hff050304);
    for (int ch = 0; ch < 4; ch++)
    begin
      period(ch, n);
      period(ch, n);
      m = 8'(32'hff050304 >> (8 * ch));
      check(n, m < 4 ? 256 + m : m);
    end
    host.wr(4'h3, 32'h0000_0100);
    period(0, n);
    period(0, n);
    period(0, m);
    check(n + m, 9);
    check(n != m, 1);
    $display("divider test done");
  endtask : t_div
  // all lock pairs, route off then on, first through register 6 alone, then through both
  task t_lock;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(i[0] ? 4'h8 : 4'h6, 32'(i[2]));
      pll_locked_in = 2'(i);
      serial_data_in = ~i[0];
      host.wr(4'hf, 32'h0);
      host.rd(4'hf, v);
      check(v[21], i[0]);
      check(v[23], i[1]);
      check(serial_out_lock_loss_pin_out, i[2] ? i[1:0] == 0 : !i[0]);
    end
    $display("lock test done");
  endtask : t_lock
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (6) @(negedge clock_in);
    reset_in = 0;
    t_reset;
    t_band;
    t_div;
    t_lock;
    end_of_test;
  end
  // watchdog well past the expected few thousand cycles
  initial
  begin
    #2000000;
    errors++;
    end_of_test;
  end
endmodule : pll_band_divider_lock_control_test
bind pll_band_divider_lock_control pll_band_divider_lock_control_sva chk (.*);
